// ==== dsfl_pkg.sv ====
`default_nettype none
package dsfl_pkg;
   localparam int NCH = 6;
   // plain register port map, word addresses
   localparam logic [7:0] REG_PRIO_EN  = 8'h00;
   localparam logic [7:0] REG_STATUS   = 8'h01;
   localparam logic [7:0] REG_BUS_CTRL = 8'h02;
   localparam logic [3:0] CH_PAGE_LO   = 4'h1;
   localparam logic [3:0] CH_PAGE_HI   = 4'h6;
   localparam logic [3:0] CH_SRC  = 4'h0;
   localparam logic [3:0] CH_DST  = 4'h1;
   localparam logic [3:0] CH_CNT  = 4'h2;
   localparam logic [3:0] CH_IDX  = 4'h3;
   localparam logic [3:0] CH_SFC  = 4'h4;
   localparam logic [3:0] CH_MODE = 4'h5;
   // fields
   localparam int PE_EN_LSB    = 0;
   localparam int PE_PRIO_LSB  = 8;
   localparam int PE_ROUTE_LSB = 14;
   localparam int BC_PEER_BIT  = 8;
   localparam int SFC_SYNC_LSB = 12;
   localparam int SFC_DWORD    = 11;
   localparam int MD_SRC_LSB   = 0;
   localparam int MD_DST_LSB   = 2;
   localparam int MD_SRC_IO    = 4;
   localparam int MD_DST_IO    = 5;
   localparam int MD_HALF_IE   = 6;
   localparam int MD_DONE_IE   = 7;
   localparam logic [15:0] RST_REG = 16'h0000;
   // sync select codes
   localparam logic [3:0] SYNC_FREE   = 4'h0;
   localparam logic [3:0] SYNC_LAST_SP = 4'h6;
   localparam logic [3:0] SYNC_RX_NE  = 4'h7;
   localparam logic [3:0] SYNC_TX_NF  = 4'h8;
   // shared line routing
   localparam logic [1:0] ROUTE_SERIAL = 2'h0;
   localparam logic [1:0] ROUTE_HIGH   = 2'h1;
   localparam logic [1:0] ROUTE_ALL    = 2'h2;
   // address step modes
   localparam logic [1:0] ADDR_CONST = 2'h0;
   localparam logic [1:0] ADDR_INC   = 2'h1;
   localparam logic [1:0] ADDR_DEC   = 2'h2;
   localparam logic [1:0] ADDR_INDEX = 2'h3;
   // core fifos
   localparam logic [3:0] FIFO_DEPTH = 4'h8;
   localparam int XFER_CYCLES = 4;
   typedef enum logic [2:0] {
      ST_IDLE, ST_READ, ST_CAPT, ST_WRITE, ST_UPDATE
   } dsfl_state_e;
   typedef struct packed {
      logic        valid;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dsfl_mem_req_s;
   typedef struct packed {
      logic external_memory_port_en;
      logic hp_en;
      logic hp_mux;
      logic hp_dir;
   } dsfl_host_mode_s;
endpackage : dsfl_pkg
`default_nettype wire

// ==== dsfl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsfl_top
   import dsfl_pkg::*;
(
   input  wire logic            sys_clk,
   input  wire logic            nrst,
   input  wire logic [7:0]      reg_addr,
   input  wire logic [15:0]     reg_wdata,
   input  wire logic            reg_wr,
   input  wire logic            reg_rd,
   output logic [15:0]          reg_rdata,
   output dsfl_mem_req_s        mem_req,
   input  wire logic [15:0]     mem_rdata,
   output logic                 cpu_stall,
   input  wire logic [5:0]      serial_evt,
   input  wire logic            serial2_rx_irq,
   input  wire logic            serial2_tx_irq,
   input  wire logic            serial1_rx_irq,
   input  wire logic            serial1_tx_irq,
   output logic [3:0]           shared_irq,
   output logic [1:0]           chan45_done_irq,
   input  wire logic            peer_wr,
   input  wire logic [15:0]     peer_wr_data,
   output logic [3:0]           in_level,
   input  wire logic            peer_rd,
   output logic [15:0]          peer_rd_data,
   output logic [3:0]           out_level,
   output logic                 peer_core_interrupt,
   input  wire logic            expansion_select_pin,
   input  wire logic            host_port_form_pin,
   input  wire logic            subsystem_select_pin,
   input  wire logic            subsystem_id,
   output dsfl_host_mode_s      host_mode
);
   function automatic logic [15:0] step_addr(
      input logic [15:0] a,
      input logic [1:0]  m,
      input logic [15:0] idx
   );
      logic [15:0] r;
      case (m)
         ADDR_INC:   r = a + 16'h0001;
         ADDR_DEC:   r = a - 16'h0001;
         ADDR_INDEX: r = a + idx;
         default:    r = a;
      endcase
      return r;
   endfunction : step_addr

   function automatic logic [3:0] fifo_cnt(
      input logic [3:0] c,
      input logic       push,
      input logic       pop
   );
      logic [3:0] r;
      r = c;
      if (push && !pop) r = c + 4'h1;
      if (pop && !push) r = c - 4'h1;
      return r;
   endfunction : fifo_cnt

   // high-priority channels first, lowest index breaks ties
   function automatic logic [3:0] pick_chan(
      input logic [5:0] rdy,
      input logic [5:0] hi
   );
      logic [3:0] r;
      r = 4'h0;
      for (int i = NCH - 1; i >= 0; i--)
         if (rdy[i]) r = {1'b1, 3'(i)};
      for (int i = NCH - 1; i >= 0; i--)
         if (rdy[i] && hi[i]) r = {1'b1, 3'(i)};
      return r;
   endfunction : pick_chan

   logic [15:0] ch_src   [NCH];
   logic [15:0] ch_dst   [NCH];
   logic [15:0] ch_cnt   [NCH];
   logic [15:0] ch_start [NCH];
   logic [15:0] ch_idx   [NCH];
   logic [15:0] ch_sfc   [NCH];
   logic [15:0] ch_mode  [NCH];
   logic [15:0] prio_en;
   logic [15:0] bus_ctrl;
   logic [5:0]  pend;
   logic [15:0] in_mem   [8];
   logic [15:0] out_mem  [8];
   logic [2:0]  in_wp, in_rp, out_wp, out_rp;
   logic [3:0]  in_cnt, out_cnt;
   dsfl_state_e state, next_state;
   logic [2:0]  cur, start_ch;
   logic        phase, pair_hold, start;
   logic [3:0]  pin_s1, pin_s2;

   // register port decode
   wire [3:0] pg     = reg_addr[7:4];
   wire       ch_hit = pg >= CH_PAGE_LO && pg <= CH_PAGE_HI;
   wire [2:0] wch    = 3'(pg - CH_PAGE_LO);
   wire       ch_wr  = reg_wr && ch_hit;
   wire       pe_wr  = reg_wr && reg_addr == REG_PRIO_EN;
   wire       bc_wr  = reg_wr && reg_addr == REG_BUS_CTRL;
   wire [5:0] ch_en  = prio_en[PE_EN_LSB +: NCH];
   wire [5:0] ch_hi  = prio_en[PE_PRIO_LSB +: NCH];
   wire [1:0] route  = prio_en[PE_ROUTE_LSB +: 2];

   // per-channel sync and readiness
   logic [3:0] sync_sel [NCH];
   logic [5:0] io_ok, rdy, pend_set;
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         sync_sel[i] = ch_sfc[i][SFC_SYNC_LSB +: 4];
         // fifo never over/underflows, whatever the sync code
         io_ok[i] = !(ch_mode[i][MD_SRC_IO] && in_cnt == 4'h0) &&
            !(ch_mode[i][MD_DST_IO] && out_cnt == FIFO_DEPTH);
         pend_set[i] = sync_sel[i] != SYNC_FREE &&
            sync_sel[i] <= SYNC_LAST_SP &&
            serial_evt[3'(sync_sel[i] - 4'h1)];
         // codes 9..15 match no term: never triggered
         rdy[i] = ch_en[i] && ch_cnt[i] != 16'h0000 && io_ok[i] &&
            (sync_sel[i] == SYNC_FREE || pend[i] ||
             (sync_sel[i] == SYNC_RX_NE && in_cnt != 4'h0) ||
             (sync_sel[i] == SYNC_TX_NF && out_cnt != FIFO_DEPTH));
      end
   end

   wire [3:0] win = pick_chan(rdy, ch_hi);

   always_comb begin
      next_state = state;
      start = 1'b0;
      start_ch = cur;
      case (state)
         ST_IDLE: begin
            if (pair_hold) begin
               if (io_ok[cur]) begin
                  next_state = ST_READ;
                  start = 1'b1;
               end
            end else if (win[3]) begin
               next_state = ST_READ;
               start = 1'b1;
               start_ch = win[2:0];
            end
         end
         ST_READ:  next_state = ST_CAPT;
         ST_CAPT:  next_state = ST_WRITE;
         ST_WRITE: next_state = ST_UPDATE;
         ST_UPDATE: next_state = ST_IDLE;
         default:  next_state = ST_IDLE;
      endcase
   end

   // current channel view
   wire [15:0] c_mode  = ch_mode[cur];
   wire        c_srcio = c_mode[MD_SRC_IO];
   wire        c_dstio = c_mode[MD_DST_IO];
   wire        c_dword = ch_sfc[cur][SFC_DWORD];
   wire [15:0] s_mode  = ch_mode[start_ch];
   wire [15:0] cnt_dec = ch_cnt[cur] - 16'h0001;
   wire        upd     = state == ST_UPDATE;
   wire        pair_end = !(c_dword && !phase);
   wire        done_hit = upd && pair_end && cnt_dec == 16'h0000;
   wire        half_hit = upd && pair_end &&
                          cnt_dec == (ch_start[cur] >> 1);
   wire [15:0] rd_val  = c_srcio ? in_mem[in_rp] : mem_rdata;
   wire        in_push = peer_wr && in_cnt != FIFO_DEPTH;
   wire        in_pop  = state == ST_CAPT && c_srcio;
   wire        out_push = state == ST_WRITE && c_dstio;
   wire        out_pop = peer_rd && out_cnt != 4'h0;

   // engine registers and memory request
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state <= ST_IDLE;
         cur <= 3'h0;
         phase <= 1'b0;
         pair_hold <= 1'b0;
         mem_req <= '0;
         cpu_stall <= 1'b0;
      end else begin
         state <= next_state;
         cur <= start_ch;
         // core is held off while the engine owns memory
         cpu_stall <= next_state == ST_READ ||
                      next_state == ST_WRITE;
         mem_req.valid <= 1'b0;
         mem_req.we <= 1'b0;
         if (start && !s_mode[MD_SRC_IO]) begin
            mem_req.valid <= 1'b1;
            mem_req.addr <= ch_src[start_ch];
         end
         if (state == ST_CAPT) begin
            mem_req.wdata <= rd_val;
            mem_req.valid <= !c_dstio;
            mem_req.we <= !c_dstio;
            mem_req.addr <= ch_dst[cur];
         end
         if (start && !pair_hold) phase <= 1'b0;
         if (upd) begin
            phase <= !pair_end;
            pair_hold <= !pair_end;
         end
      end
   end

   // channel context registers; software write wins
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         for (int i = 0; i < NCH; i++) begin
            ch_src[i] <= RST_REG;
            ch_dst[i] <= RST_REG;
            ch_cnt[i] <= RST_REG;
            ch_start[i] <= RST_REG;
            ch_idx[i] <= RST_REG;
            ch_sfc[i] <= RST_REG;
            ch_mode[i] <= RST_REG;
         end
      end else begin
         if (upd) begin
            ch_src[cur] <= step_addr(ch_src[cur],
               c_mode[MD_SRC_LSB +: 2], ch_idx[cur]);
            ch_dst[cur] <= step_addr(ch_dst[cur],
               c_mode[MD_DST_LSB +: 2], ch_idx[cur]);
            if (pair_end) ch_cnt[cur] <= cnt_dec;
         end
         if (ch_wr) begin
            case (reg_addr[3:0])
               CH_SRC: ch_src[wch] <= reg_wdata;
               CH_DST: ch_dst[wch] <= reg_wdata;
               CH_CNT: begin
                  ch_cnt[wch] <= reg_wdata;
                  ch_start[wch] <= reg_wdata;
               end
               CH_IDX:  ch_idx[wch] <= reg_wdata;
               CH_SFC:  ch_sfc[wch] <= reg_wdata;
               CH_MODE: ch_mode[wch] <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   // global control, pending triggers, peer request
   logic [5:0] done_ev, half_ev;
   always_comb begin
      done_ev = '0;
      half_ev = '0;
      done_ev[cur] = done_hit && c_mode[MD_DONE_IE];
      half_ev[cur] = half_hit && c_mode[MD_HALF_IE];
   end
   wire [5:0] ch_irq = done_ev | half_ev;
   logic [5:0] consume;
   always_comb begin
      consume = '0;
      consume[start_ch] = start && !pair_hold;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         prio_en <= RST_REG;
         bus_ctrl <= RST_REG;
         pend <= '0;
         peer_core_interrupt <= 1'b0;
      end else begin
         // an event in the consuming cycle is kept
         pend <= (pend & ~consume) | pend_set;
         if (done_hit) prio_en[PE_EN_LSB + 32'(cur)] <= 1'b0;
         if (pe_wr) prio_en <= reg_wdata;
         if (bc_wr) bus_ctrl <= reg_wdata & ~(16'h0001 << BC_PEER_BIT);
         peer_core_interrupt <= bc_wr && reg_wdata[BC_PEER_BIT];
      end
   end

   // shared interrupt lines 6,7,10,11
   wire r_all = route == ROUTE_ALL;
   wire r_hi  = r_all || route == ROUTE_HIGH;
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         shared_irq <= '0;
         chan45_done_irq <= '0;
      end else begin
         shared_irq[0] <= r_all ? ch_irq[0] : serial2_rx_irq;
         shared_irq[1] <= r_all ? ch_irq[1] : serial2_tx_irq;
         shared_irq[2] <= r_hi ? ch_irq[2] : serial1_rx_irq;
         shared_irq[3] <= r_hi ? ch_irq[3] : serial1_tx_irq;
         chan45_done_irq <= ch_irq[5:4];
      end
   end

   // core-to-core fifos, storage in flops
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         in_wp <= 3'h0;
         in_rp <= 3'h0;
         in_cnt <= 4'h0;
         out_wp <= 3'h0;
         out_rp <= 3'h0;
         out_cnt <= 4'h0;
         peer_rd_data <= RST_REG;
      end else begin
         if (in_push) begin
            in_mem[in_wp] <= peer_wr_data;
            in_wp <= in_wp + 3'h1;
         end
         if (in_pop) in_rp <= in_rp + 3'h1;
         in_cnt <= fifo_cnt(in_cnt, in_push, in_pop);
         if (out_push) begin
            out_mem[out_wp] <= mem_req.wdata;
            out_wp <= out_wp + 3'h1;
         end
         if (out_pop) begin
            peer_rd_data <= out_mem[out_rp];
            out_rp <= out_rp + 3'h1;
         end
         out_cnt <= fifo_cnt(out_cnt, out_push, out_pop);
      end
   end
   assign in_level = in_cnt;
   assign out_level = out_cnt;

   // pins: {id, expansion, form, select}, two flops each
   wire p_sel = pin_s2[0];
   wire p_frm = pin_s2[1];
   wire p_xio = pin_s2[2];
   wire me    = p_sel == pin_s2[3];
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         host_mode <= '0;
      end else begin
         pin_s1 <= {subsystem_id, expansion_select_pin,
                    host_port_form_pin, subsystem_select_pin};
         pin_s2 <= pin_s1;
         host_mode.external_memory_port_en <= p_xio && me;
         host_mode.hp_en <= p_xio ? (p_frm && !me) : me;
         host_mode.hp_mux <= !p_xio && !p_frm;
         host_mode.hp_dir <= p_xio && p_frm && p_sel;
      end
   end

   // register read, data in the following cycle
   logic [15:0] rd_mux;
   always_comb begin
      rd_mux = 16'h0000;
      if (ch_hit) begin
         case (reg_addr[3:0])
            CH_SRC:  rd_mux = ch_src[wch];
            CH_DST:  rd_mux = ch_dst[wch];
            CH_CNT:  rd_mux = ch_cnt[wch];
            CH_IDX:  rd_mux = ch_idx[wch];
            CH_SFC:  rd_mux = ch_sfc[wch];
            CH_MODE: rd_mux = ch_mode[wch];
            default: rd_mux = 16'h0000;
         endcase
      end else if (reg_addr == REG_PRIO_EN) begin
         rd_mux = prio_en;
      end else if (reg_addr == REG_BUS_CTRL) begin
         rd_mux = bus_ctrl;
      end else if (reg_addr == REG_STATUS) begin
         rd_mux = {4'h0, cur, state != ST_IDLE, out_cnt, in_cnt};
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) reg_rdata <= RST_REG;
      else if (reg_rd) reg_rdata <= rd_mux;
      else reg_rdata <= RST_REG;
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   sequence s_move;
      state == ST_READ ##1 state == ST_CAPT ##1
      state == ST_WRITE ##1 state == ST_UPDATE;
   endsequence
   a_mem_beats_core: assert property (
      mem_req.valid |-> cpu_stall)
      else $error("engine access without core stall");
   a_move_four_cyc: assert property (
      (state == ST_IDLE && start) |=> s_move ##1 state == ST_IDLE)
      else $error("element move not four cycles");
   a_reserved_idle: assert property (
      (start && !pair_hold) |-> sync_sel[start_ch] <= SYNC_TX_NF)
      else $error("reserved sync code started");
   a_route_reset: assert property (
      $rose(nrst) |-> route == ROUTE_SERIAL && !prio_en[15])
      else $error("shared lines not serial after reset");
   a_peer_irq: assert property (
      peer_core_interrupt == ($past(bc_wr) && $past(reg_wdata[BC_PEER_BIT])))
      else $error("peer interrupt mismatch");
   a_in_no_under: assert property (
      in_pop |-> in_cnt != 4'h0 && in_cnt <= FIFO_DEPTH)
      else $error("incoming fifo underflow");
   a_out_no_over: assert property (
      out_push |-> $past(out_cnt) != FIFO_DEPTH || $past(out_pop))
      else $error("outgoing fifo overflow");
   a_external_memory_port_single: assert property (
      $past(p_xio) && !$past(p_frm) && !$past(me) |->
      !host_mode.external_memory_port_en && !host_mode.hp_en)
      else $error("deselected side granted external port");
   a_dword_pair: assert property (
      (upd && c_dword && !phase && !ch_wr) |=> pair_hold &&
      $stable(ch_cnt[cur]))
      else $error("double word pair broken");
endmodule : dsfl_top
`default_nettype wire

// ==== dsfl_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dsfl_mem_model
   import dsfl_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire dsfl_mem_req_s mem_req,
   output logic [15:0]        mem_rdata
);
   logic [15:0] mem [256];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 16'ha000 + 16'(i);
      end
   end
   // data stands one cycle only; toggling otherwise so stale use shows
   always @(posedge sys_clk) begin
      if (mem_req.valid && mem_req.we) begin
         mem[mem_req.addr[7:0]] <= mem_req.wdata;
      end
      if (mem_req.valid && !mem_req.we) begin
         mem_rdata <= mem[mem_req.addr[7:0]];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : dsfl_mem_model
`default_nettype wire

// ==== tb_dsfl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_dsfl_top
   import dsfl_pkg::*;
   ;
   logic            sys_clk, nrst, reg_wr, reg_rd, peer_wr, peer_rd;
   logic [7:0]      reg_addr;
   logic [15:0]     reg_wdata, reg_rdata, mem_rdata, peer_wr_data;
   logic [15:0]     peer_rd_data;
   dsfl_mem_req_s   mem_req;
   logic            cpu_stall, peer_core_interrupt, sub_id, gap_chk;
   logic [5:0]      serial_evt;
   logic [3:0]      sirq, shared_irq, in_level, out_level;
   logic [1:0]      chan45_done_irq, route;
   logic [2:0]      pins;
   dsfl_host_mode_s host_mode;
   int              failures = 0;
   int              samples_checked = 0;
   int              irq_cnt = 0, cyc = 0, rd_cyc = 0, c45_cnt = 0;

   dsfl_top dut_u (
      .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_rdata(mem_rdata),
      .cpu_stall(cpu_stall), .serial_evt(serial_evt),
      .serial2_rx_irq(sirq[0]), .serial2_tx_irq(sirq[1]),
      .serial1_rx_irq(sirq[2]), .serial1_tx_irq(sirq[3]),
      .shared_irq(shared_irq), .chan45_done_irq(chan45_done_irq),
      .peer_wr(peer_wr), .peer_wr_data(peer_wr_data),
      .in_level(in_level), .peer_rd(peer_rd),
      .peer_rd_data(peer_rd_data), .out_level(out_level),
      .peer_core_interrupt(peer_core_interrupt),
      .expansion_select_pin(pins[2]), .host_port_form_pin(pins[1]),
      .subsystem_select_pin(pins[0]), .subsystem_id(sub_id),
      .host_mode(host_mode)
   );
   dsfl_mem_model mem_u (
      .sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [15:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (nrst && shared_irq[0]) irq_cnt = irq_cnt + 1;
      if (nrst && chan45_done_irq[0]) c45_cnt = c45_cnt + 1;
      if (mem_req.valid) begin
         chk("stall", 16'h0001, 16'(cpu_stall));
         if (!mem_req.we) rd_cyc = cyc;
         else if (gap_chk) chk("gap", 16'h0002, 16'(cyc - rd_cyc));
      end
   end

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic prog(input int n, input logic [15:0] s, d, c, x, f, m);
      wr({CH_PAGE_LO + 4'(n), CH_SRC}, s);
      wr({CH_PAGE_LO + 4'(n), CH_DST}, d);
      wr({CH_PAGE_LO + 4'(n), CH_CNT}, c);
      wr({CH_PAGE_LO + 4'(n), CH_IDX}, x);
      wr({CH_PAGE_LO + 4'(n), CH_SFC}, f);
      wr({CH_PAGE_LO + 4'(n), CH_MODE}, m);
      wr(REG_PRIO_EN, {route, 8'h00, 6'(1 << n)});
   endtask : prog

   task automatic wait_done(input int n);
      logic [15:0] v;
      v = 16'hffff;
      for (int i = 0; i < 40 && v[n]; i++) rd(REG_PRIO_EN, v);
      chk("enable", 16'h0000, 16'(v[n]));
   endtask : wait_done

   task automatic push(input logic [15:0] d);
      @(posedge sys_clk);
      peer_wr      <= 1'b1;
      peer_wr_data <= d;
      @(posedge sys_clk);
      peer_wr <= 1'b0;
   endtask : push

   task automatic pop(output logic [15:0] d);
      @(posedge sys_clk);
      peer_rd <= 1'b1;
      @(posedge sys_clk);
      peer_rd <= 1'b0;
      #1 d = peer_rd_data;
   endtask : pop

   task automatic t_reset();
      logic [15:0] v;
      rd(REG_PRIO_EN, v);
      chk("prio_en", 16'h0000, v);
      rd(8'hff, v);
      chk("unmapped", 16'h0000, v);
      chk("lines", 16'h000a, 16'(shared_irq));
   endtask : t_reset

   task automatic t_route();
      logic [3:0] e [3];
      e = '{4'hf, 4'h3, 4'h0};
      @(posedge sys_clk);
      sirq <= 4'hf;
      for (int r = 0; r < 3; r++) begin
         route = 2'(r);
         wr(REG_PRIO_EN, {route, 14'h0000});
         repeat (2) @(posedge sys_clk);
         #1 chk("route", 16'(e[r]), 16'(shared_irq));
      end
      @(posedge sys_clk);
      sirq <= 4'h0;
   endtask : t_route

   task automatic t_copy();
      int base;
      base = irq_cnt;
      gap_chk = 1'b1;
      prog(0, 16'h0010, 16'h0040, 16'h0002, 16'h0000, 16'h0000,
           {8'h00, 2'b11, 2'b00, ADDR_DEC, ADDR_INC});
      wait_done(0);
      repeat (4) @(posedge sys_clk);
      gap_chk = 1'b0;
      chk("m40", 16'ha010, mem_u.mem[8'h40]);
      chk("m3f", 16'ha011, mem_u.mem[8'h3f]);
      chk("irqs", 16'h0002, 16'(irq_cnt - base));
   endtask : t_copy

   task automatic t_dword();
      prog(1, 16'h0020, 16'h0080, 16'h0001, 16'h0005, 16'h0800,
           {8'h00, 4'h0, ADDR_INDEX, ADDR_INC});
      wait_done(1);
      chk("m80", 16'ha020, mem_u.mem[8'h80]);
      chk("m85", 16'ha021, mem_u.mem[8'h85]);
      chk("m81", 16'ha081, mem_u.mem[8'h81]);
   endtask : t_dword

   task automatic t_fifo_in();
      prog(2, 16'h0000, 16'h0090, 16'h0002, 16'h0000,
           {SYNC_RX_NE, 12'h000}, {8'h00, 4'h1, ADDR_INC, ADDR_CONST});
      repeat (20) @(posedge sys_clk);
      chk("m90", 16'ha090, mem_u.mem[8'h90]);
      push(16'h5a01);
      push(16'h5a02);
      wait_done(2);
      chk("m90", 16'h5a01, mem_u.mem[8'h90]);
      chk("m91", 16'h5a02, mem_u.mem[8'h91]);
      chk("in_lvl", 16'h0000, 16'(in_level));
   endtask : t_fifo_in

   task automatic t_fifo_out();
      logic [15:0] v;
      prog(3, 16'h0030, 16'h0000, 16'h0009, 16'h0000,
           {SYNC_TX_NF, 12'h000}, {8'h00, 4'h2, ADDR_CONST, ADDR_INC});
      repeat (100) @(posedge sys_clk);
      chk("out_lvl", 16'h0008, 16'(out_level));
      rd(REG_STATUS, v);
      chk("status", 16'h0008, 16'(v[7:4]));
      pop(v);
      chk("pop", 16'ha030, v);
      wait_done(3);
      for (int i = 1; i < 9; i++) begin
         pop(v);
         chk("pop", 16'ha030 + 16'(i), v);
      end
      chk("m00", 16'ha000, mem_u.mem[8'h00]);
   endtask : t_fifo_out

   task automatic t_sync();
      logic [15:0] v;
      int          base;
      base = c45_cnt;
      for (int c = 1; c < 7; c++) begin
         prog(4, 16'h0050 + 16'(c), 16'h00a0 + 16'(c), 16'h0001,
              16'h0000, {4'(c), 12'h000}, 16'h0085);
         repeat (12) @(posedge sys_clk);
         chk("idle", 16'ha0a0 + 16'(c), mem_u.mem[8'ha0 + 8'(c)]);
         @(posedge sys_clk);
         serial_evt <= 6'(1 << (c - 1));
         @(posedge sys_clk);
         serial_evt <= 6'h00;
         wait_done(4);
         chk("synced", 16'ha050 + 16'(c), mem_u.mem[8'ha0 + 8'(c)]);
      end
      prog(5, 16'h0060, 16'h00b0, 16'h0001, 16'h0000, 16'h9000, 16'h0005);
      repeat (30) @(posedge sys_clk);
      chk("rsvd", 16'ha0b0, mem_u.mem[8'hb0]);
      rd(REG_PRIO_EN, v);
      chk("rsvd_en", 16'h0001, 16'(v[5]));
      chk("c45", 16'h0006, 16'(c45_cnt - base));
      wr(REG_PRIO_EN, {route, 14'h0000});
   endtask : t_sync

   task automatic t_peer();
      logic [15:0] v;
      logic [15:0] hits;
      hits = 16'h0000;
      wr(REG_BUS_CTRL, 16'h0105);
      // pulse stands in the cycle right after the write edge
      for (int i = 0; i < 4; i++) begin
         #1 hits = hits + 16'(peer_core_interrupt);
         @(posedge sys_clk);
      end
      chk("peer_irq", 16'h0001, hits);
      rd(REG_BUS_CTRL, v);
      chk("bus_ctrl", 16'h0005, v);
   endtask : t_peer

   task automatic t_pins();
      logic [3:0] e;
      logic       own;
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk);
         {sub_id, pins} <= 4'(k);
         repeat (5) @(posedge sys_clk);
         #1 own = (pins[0] == sub_id);
         if (!pins[2]) e = {1'b0, own, own & !pins[1], 1'b0};
         else e = {own, pins[1] & !own, 1'b0, pins[1] & pins[0]};
         chk("host", 16'(e), 16'({host_mode.external_memory_port_en, host_mode.hp_en,
             host_mode.hp_mux & host_mode.hp_en,
             host_mode.hp_dir}));
      end
   endtask : t_pins

   task automatic finish_test();
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (30000) @(posedge sys_clk);
      failures++;
      finish_test();
   end

   initial begin
      {nrst, reg_wr, reg_rd, peer_wr, peer_rd, sub_id, gap_chk} = 7'h00;
      {reg_addr, reg_wdata, peer_wr_data} = 40'h00_0000_0000;
      {serial_evt, pins, route} = '0;
      sirq = 4'ha;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_route();
      t_copy();
      t_dword();
      t_fifo_in();
      t_fifo_out();
      t_sync();
      t_peer();
      t_pins();
      finish_test();
   end
endmodule : tb_dsfl_top
`default_nettype wire
